// File: inc/mlsf_pkg.sv
// Purpose: shared constants and carriers for the link status flag bank
// Assumes: one station, eight station slots, 32-bit AXI4-Lite data
// Notes:   offsets are byte addresses on the register bus
package mlsf_pkg;

	// Bus geometry
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int STRB_W    = 4;
	localparam int WORD_LSB  = 2;

	// Station geometry; index 0 is the master, 1 to 7 the slaves
	localparam int NUM_STN   = 8;
	localparam int STN_W     = 3;
	localparam int CNT_W     = 16;
	localparam int CODE_W    = 16;
	localparam int RETRY_W   = 4;
	localparam logic [RETRY_W-1:0] RETRY_DEF = 4'h3;
	localparam logic [RETRY_W-1:0] RETRY_MAX = 4'hA;

	// Error codes written on a parameter error (decimal 6308 and 3808)
	localparam logic [CODE_W-1:0] CODE_PARAM_CH1 = 16'h18A4;
	localparam logic [CODE_W-1:0] CODE_PARAM_CH2 = 16'h0EE0;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FLAGS    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CODE1    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CODE2    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CNT_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_CNT_LAST = 8'h3C;

	// Control word fields
	localparam int CTL_CHSEL   = 0;
	localparam int CTL_STN_LSB = 4;
	localparam int CTL_RTY_LSB = 8;

	// Flag word fields
	localparam int FLG_SETUP   = 0;
	localparam int FLG_P1      = 1;
	localparam int FLG_P2      = 2;
	localparam int FLG_XFER    = 3;
	localparam int FLG_SEQ_LSB = 8;

	// Interrupt status bits
	localparam int IRQ_W       = 5;
	localparam int IRQ_P1      = 0;
	localparam int IRQ_P2      = 1;
	localparam int IRQ_C1      = 2;
	localparam int IRQ_C2      = 3;
	localparam int IRQ_SEQ     = 4;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Events from the channel engines
	typedef struct packed {
		logic              ch1_param_err;
		logic              ch2_param_err;
		logic              ch1_comm_err;
		logic              ch2_comm_err;
		logic [CODE_W-1:0] ch1_code;
		logic [CODE_W-1:0] ch2_code;
		logic              xfer_exec;
	} mlsf_link_evt_s;

	// Per-station observations, one bit per station index
	typedef struct packed {
		logic [NUM_STN-1:0] no_resp;
		logic [NUM_STN-1:0] resp_ok;
		logic [NUM_STN-1:0] seq_err;
	} mlsf_stn_evt_s;

endpackage

// File: logic/mlsf_station_tracker.sv
// Purpose: sequence error flag, retry tracking and error count of one station
// Assumes: event inputs are single-cycle pulses
// Notes:   a set in the clearing cycle wins, the count restarts at one
`timescale 1ns/10ps
module mlsf_station_tracker #(
	parameter int CNT_W   = mlsf_pkg::CNT_W,
	parameter int RETRY_W = mlsf_pkg::RETRY_W
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Control
	input  wire logic               clear,
	input  wire logic               enable,
	input  wire logic [RETRY_W-1:0] retries,
	// Observations
	input  wire logic               no_resp,
	input  wire logic               resp_ok,
	input  wire logic               seq_err,
	// Status
	output logic                    flag_reg,
	output logic [CNT_W-1:0]        count_reg,
	output logic                    new_err_reg
);
	import mlsf_pkg::*;

	logic [RETRY_W-1:0] miss_reg;
	logic               limit_hit;
	logic               err_hit;

	// Silent station after the retries are used up
	assign limit_hit = no_resp && (miss_reg == retries);
	assign err_hit   = enable && (seq_err || limit_hit);

	// Missed answers since the last good one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			miss_reg <= '0;
		end else if (clear || resp_ok || limit_hit) begin
			miss_reg <= '0;
		end else if (no_resp) begin
			miss_reg <= miss_reg + 1'b1;
		end
	end

	// Sticky flag, set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
		end else if (err_hit) begin
			flag_reg <= 1'b1;
		end else if (clear) begin
			flag_reg <= 1'b0;
		end
	end

	// Saturating error count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (err_hit && clear) begin
			count_reg <= CNT_W'(1);
		end else if (err_hit && !(&count_reg)) begin
			count_reg <= count_reg + 1'b1;
		end else if (clear) begin
			count_reg <= '0;
		end
	end

	// Event pulse for the interrupt status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			new_err_reg <= 1'b0;
		end else begin
			new_err_reg <= err_hit;
		end
	end

	a_retry_limit: assert property (@(posedge clk) disable iff (!rst_n)
		enable && no_resp && miss_reg == retries |=> flag_reg && new_err_reg)
		else $error("silent station not flagged after retries");

	a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
		err_hit && !clear && !(&count_reg) |=> count_reg == $past(count_reg) + 1'b1)
		else $error("sequence error count did not step");

	a_seq_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		enable && seq_err |=> flag_reg ##1 (flag_reg || $past(clear)))
		else $error("sequence error flag not set or lost");

endmodule

// File: logic/mlsf_top.sv
// Purpose: status, error flags and codes of one station on a multidrop link
// Assumes: link engine error events are one-cycle pulses synchronous to clk; xfer_exec is a level
// Notes:   AXI4-Lite slave; one write and one read in flight at a time
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module mlsf_top #(
	parameter int ADDR_W = mlsf_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0]      s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Station mode
	input  wire logic                   run_mode,
	input  wire logic                   setup_block_end,
	// Link events
	input  wire mlsf_pkg::mlsf_link_evt_s link_evt,
	input  wire mlsf_pkg::mlsf_stn_evt_s  stn_evt,
	// Station outputs
	output logic                        param_setup_flag,
	output logic                        second_channel_select,
	output logic [mlsf_pkg::STN_W-1:0]  station_number,
	output logic                        transfer_active,
	output logic                        irq
);
	import mlsf_pkg::*;

	// Byte-lane mask from write strobes
	function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] s);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < STRB_W; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// Decode of the implemented word addresses
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = (a[WORD_LSB-1:0] == '0);
		hit = hit && ((a <= OFF_IRQ_MASK) || (a >= OFF_CNT_BASE && a <= OFF_CNT_LAST));
		return hit;
	endfunction

	logic rst_meta_reg;
	logic rst_n_reg;

	// Reset release through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	logic                run_q_reg;
	logic                run_edge;
	logic                setup_reg;
	logic                p1_reg;
	logic                p2_reg;
	logic [CODE_W-1:0]   code1_reg;
	logic [CODE_W-1:0]   code2_reg;
	logic                xfer_reg;
	logic                chsel_reg;
	logic [STN_W-1:0]    stn_reg;
	logic [RETRY_W-1:0]  retry_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_mask_reg;
	logic [IRQ_W-1:0]    irq_set;
	logic [IRQ_W-1:0]    irq_clr;
	logic                irq_reg;
	logic [NUM_STN-1:0]  seq_flag;
	logic [NUM_STN-1:0]  seq_new;
	logic [CNT_W-1:0]    seq_cnt [NUM_STN];

	// Stop-to-run change detect
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			run_q_reg <= 1'b0;
		end else begin
			run_q_reg <= run_mode;
		end
	end
	assign run_edge = run_mode && !run_q_reg;

	// One-shot setup window from run entry to end of the setup block
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			setup_reg <= 1'b0;
		end else if (run_edge) begin
			setup_reg <= 1'b1;
		end else if (setup_block_end || !run_mode) begin
			setup_reg <= 1'b0;
		end
	end

	// Parameter error flags, sticky until stop-to-run
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			p1_reg <= 1'b0;
			p2_reg <= 1'b0;
		end else begin
			p1_reg <= link_evt.ch1_param_err || (p1_reg && !run_edge);
			p2_reg <= link_evt.ch2_param_err || (p2_reg && !run_edge);
		end
	end

	// Channel one error code word
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			code1_reg <= '0;
		end else if (link_evt.ch1_param_err) begin
			code1_reg <= CODE_PARAM_CH1;
		end else if (link_evt.ch1_comm_err) begin
			code1_reg <= link_evt.ch1_code;
		end else if (run_edge) begin
			code1_reg <= '0;
		end
	end

	// Channel two error code word
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			code2_reg <= '0;
		end else if (link_evt.ch2_param_err) begin
			code2_reg <= CODE_PARAM_CH2;
		end else if (link_evt.ch2_comm_err) begin
			code2_reg <= link_evt.ch2_code;
		end else if (run_edge) begin
			code2_reg <= '0;
		end
	end

	// Transfer execution level
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			xfer_reg <= 1'b0;
		end else begin
			xfer_reg <= link_evt.xfer_exec;
		end
	end

	// Per-station sequence trackers, index 0 is the master
	for (genvar i = 0; i < NUM_STN; i++) begin : g_stn
		mlsf_station_tracker #(
			.CNT_W   (CNT_W),
			.RETRY_W (RETRY_W)
		) u_trk (
			.clk         (clk),
			.rst_n       (rst_n_reg),
			.clear       (run_edge),
			.enable      (STN_W'(i) != stn_reg),
			.retries     (retry_reg),
			.no_resp     (stn_evt.no_resp[i]),
			.resp_ok     (stn_evt.resp_ok[i]),
			.seq_err     (stn_evt.seq_err[i]),
			.flag_reg    (seq_flag[i]),
			.count_reg   (seq_cnt[i]),
			.new_err_reg (seq_new[i])
		);
	end

	// AXI write path
	logic                aw_have_reg;
	logic                w_have_reg;
	logic                awready_reg;
	logic                wready_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic [ADDR_W-1:0]   awaddr_reg;
	logic [DATA_W-1:0]   wdata_reg;
	logic [STRB_W-1:0]   wstrb_reg;
	logic                wr_go;
	logic [DATA_W-1:0]   wmask;
	logic [DATA_W-1:0]   ctrl_old;
	logic [DATA_W-1:0]   ctrl_new;
	logic [RETRY_W-1:0]  rty_new;

	assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wmask = lane_mask(wstrb_reg);

	// Address and data captured in either order
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			aw_have_reg <= 1'b0;
			awready_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (s_axi_awvalid && awready_reg) begin
			aw_have_reg <= 1'b1;
			awready_reg <= 1'b0;
			awaddr_reg  <= s_axi_awaddr;
		end else begin
			if (wr_go) begin
				aw_have_reg <= 1'b0;
			end
			awready_reg <= !aw_have_reg && !bvalid_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			w_have_reg <= 1'b0;
			wready_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
		end else if (s_axi_wvalid && wready_reg) begin
			w_have_reg <= 1'b1;
			wready_reg <= 1'b0;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end else begin
			if (wr_go) begin
				w_have_reg <= 1'b0;
			end
			wready_reg <= !w_have_reg && !bvalid_reg;
		end
	end

	// Write response, error for unmapped words
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Control word merge by byte lane, retries clamped to the legal range
	always_comb begin
		ctrl_old = '0;
		ctrl_old[CTL_CHSEL] = chsel_reg;
		ctrl_old[CTL_STN_LSB +: STN_W] = stn_reg;
		ctrl_old[CTL_RTY_LSB +: RETRY_W] = retry_reg;
		ctrl_new = (ctrl_old & ~wmask) | (wdata_reg & wmask);
		rty_new = ctrl_new[CTL_RTY_LSB +: RETRY_W];
		if (rty_new > RETRY_MAX) begin
			rty_new = RETRY_MAX;
		end
	end

	// Only control, mask and interrupt status (write-one clear) words take writes; flags, codes and counts ignore them
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			chsel_reg <= 1'b0;
			stn_reg   <= '0;
			retry_reg <= RETRY_DEF;
		end else if (wr_go && awaddr_reg == OFF_CTRL) begin
			chsel_reg <= ctrl_new[CTL_CHSEL];
			stn_reg   <= ctrl_new[CTL_STN_LSB +: STN_W];
			retry_reg <= rty_new;
		end
	end

	// Interrupt events; a set wins over a write-one clear
	assign irq_set[IRQ_P1]  = link_evt.ch1_param_err;
	assign irq_set[IRQ_P2]  = link_evt.ch2_param_err;
	assign irq_set[IRQ_C1]  = link_evt.ch1_comm_err;
	assign irq_set[IRQ_C2]  = link_evt.ch2_comm_err;
	assign irq_set[IRQ_SEQ] = |seq_new;
	assign irq_clr = (wr_go && awaddr_reg == OFF_IRQ_STAT) ?
		(wdata_reg[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_mask_reg <= '0;
		end else if (wr_go && awaddr_reg == OFF_IRQ_MASK) begin
			irq_mask_reg <= (irq_mask_reg & ~wmask[IRQ_W-1:0])
				| (wdata_reg[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
		end
	end

	// Interrupt line from unmasked sticky bits
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// AXI read path
	logic                arready_reg;
	logic                rvalid_reg;
	logic [DATA_W-1:0]   rdata_reg;
	logic [1:0]          rresp_reg;
	logic [DATA_W-1:0]   rd_word;
	logic [STN_W-1:0]    rd_idx;

	assign rd_idx = s_axi_araddr[WORD_LSB +: STN_W];

	// Read mux of live state
	always_comb begin
		rd_word = '0;
		case (s_axi_araddr)
			OFF_CTRL: begin
				rd_word[CTL_CHSEL] = chsel_reg;
				rd_word[CTL_STN_LSB +: STN_W] = stn_reg;
				rd_word[CTL_RTY_LSB +: RETRY_W] = retry_reg;
			end
			OFF_FLAGS: begin
				rd_word[FLG_SETUP] = setup_reg;
				rd_word[FLG_P1] = p1_reg;
				rd_word[FLG_P2] = p2_reg;
				rd_word[FLG_XFER] = xfer_reg;
				rd_word[FLG_SEQ_LSB +: NUM_STN] = seq_flag;
			end
			OFF_CODE1: rd_word = DATA_W'(code1_reg);
			OFF_CODE2: rd_word = DATA_W'(code2_reg);
			OFF_IRQ_STAT: rd_word = DATA_W'(irq_stat_reg);
			OFF_IRQ_MASK: rd_word = DATA_W'(irq_mask_reg);
			default: begin
				if (is_mapped(s_axi_araddr) && s_axi_araddr >= OFF_CNT_BASE) begin
					rd_word = DATA_W'(seq_cnt[rd_idx]);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_word;
			rresp_reg   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
		end else begin
			arready_reg <= !rvalid_reg;
		end
	end

	// Port drive from flops
	assign s_axi_awready         = awready_reg;
	assign s_axi_wready          = wready_reg;
	assign s_axi_bvalid          = bvalid_reg;
	assign s_axi_bresp           = bresp_reg;
	assign s_axi_arready         = arready_reg;
	assign s_axi_rvalid          = rvalid_reg;
	assign s_axi_rdata           = rdata_reg;
	assign s_axi_rresp           = rresp_reg;
	assign param_setup_flag      = setup_reg;
	assign second_channel_select = chsel_reg;
	assign station_number        = stn_reg;
	assign transfer_active       = xfer_reg;
	assign irq                   = irq_reg;

	a_setup_start: assert property (@(posedge clk) disable iff (!rst_n_reg)
		run_edge |=> param_setup_flag)
		else $error("setup flag not raised on run entry");

	a_setup_end: assert property (@(posedge clk) disable iff (!rst_n_reg)
		setup_block_end && !run_edge |=> !param_setup_flag ##1 (!param_setup_flag || $past(run_edge)))
		else $error("setup flag outlived the setup block");

	a_ch1_flag: assert property (@(posedge clk) disable iff (!rst_n_reg)
		link_evt.ch1_param_err |=> p1_reg && irq_stat_reg[IRQ_P1])
		else $error("channel one parameter error not flagged");

	a_ch2_flag: assert property (@(posedge clk) disable iff (!rst_n_reg)
		link_evt.ch2_param_err |=> p2_reg && irq_stat_reg[IRQ_P2])
		else $error("channel two parameter error not flagged");

	a_own_station: assert property (@(posedge clk) disable iff (!rst_n_reg)
		$stable(stn_reg) && !seq_flag[stn_reg] |=> !seq_flag[$past(stn_reg)])
		else $error("own station sequence error flagged");

	a_xfer_follow: assert property (@(posedge clk) disable iff (!rst_n_reg)
		link_evt.xfer_exec [*2] |-> transfer_active)
		else $error("transfer active low during transfer");

	a_ch1_code: assert property (@(posedge clk) disable iff (!rst_n_reg)
		link_evt.ch1_param_err |=> code1_reg == CODE_PARAM_CH1)
		else $error("channel one parameter code wrong");

	a_ch2_code: assert property (@(posedge clk) disable iff (!rst_n_reg)
		link_evt.ch2_param_err |=> code2_reg == CODE_PARAM_CH2)
		else $error("channel two parameter code wrong");

	a_sticky_err: assert property (@(posedge clk) disable iff (!rst_n_reg)
		p1_reg && !run_edge |=> p1_reg && $stable(code1_reg) || link_evt.ch1_comm_err
			|| $past(link_evt.ch1_comm_err) || $past(link_evt.ch1_param_err))
		else $error("latched channel one error lost");

	a_run_clear: assert property (@(posedge clk) disable iff (!rst_n_reg)
		run_edge && !link_evt.ch1_param_err && !link_evt.ch1_comm_err
			|=> !p1_reg && code1_reg == '0)
		else $error("stop-to-run did not clear channel one errors");

endmodule

// File: verif/mlsf_peer_model.sv
// Purpose: peer stations on the link, turning bench commands into link events
// Assumes: one command pulse per event, ops 0..6 as listed below
// Notes:   code lines show a changing pattern whenever no comm error is reported
`timescale 1ns/10ps
module mlsf_peer_model (
	// Command from the bench
	input  wire logic                      clk,
	input  wire logic                      go,
	input  wire logic [2:0]                op,
	input  wire logic [2:0]                stn,
	input  wire logic [15:0]               code,
	input  wire logic                      xfer,
	// Events toward the station
	output mlsf_pkg::mlsf_link_evt_s       link_evt,
	output mlsf_pkg::mlsf_stn_evt_s        stn_evt
);
	import mlsf_pkg::*;

	// Quiet link at start
	initial begin
		link_evt = '0;
		stn_evt  = '0;
	end

	// Peers only report events, never drive device-owned flags
	// A silent peer shows as no_resp pulses until retries run out
	always @(posedge clk) begin
		link_evt.ch1_param_err <= go && op == 3'h0;
		link_evt.ch2_param_err <= go && op == 3'h1;
		link_evt.ch1_comm_err  <= go && op == 3'h2;
		link_evt.ch2_comm_err  <= go && op == 3'h3;
		link_evt.ch1_code      <= (go && op == 3'h2) ? code : ~link_evt.ch1_code;
		link_evt.ch2_code      <= (go && op == 3'h3) ? code : ~link_evt.ch2_code;
		link_evt.xfer_exec     <= xfer;
		stn_evt.seq_err        <= (go && op == 3'h4) ? 8'h01 << stn : 8'h00;
		stn_evt.no_resp        <= (go && op == 3'h5) ? 8'h01 << stn : 8'h00;
		stn_evt.resp_ok        <= (go && op == 3'h6) ? 8'h01 << stn : 8'h00;
	end
endmodule

// File: verif/multidrop_link_status_flags_tb.sv
// Purpose: self-checking bench for the link status flag bank
// Assumes: AXI4-Lite master tasks, peer model drives link events
// Notes:   random stations and codes from a fixed seed
`timescale 1ns/10ps
module multidrop_link_status_flags_tb;
	import mlsf_pkg::*;
	logic           clk, rstn, run_mode, setup_block_end, go, xfer;
	logic [7:0]     s_axi_awaddr, s_axi_araddr, exp_seq;
	logic [31:0]    s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0]     s_axi_wstrb;
	logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic           s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]     s_axi_bresp, s_axi_rresp, resp;
	logic [2:0]     op, stn, station_number;
	logic [15:0]    code;
	logic           param_setup_flag, second_channel_select, transfer_active, irq;
	mlsf_link_evt_s link_evt;
	mlsf_stn_evt_s  stn_evt;
	int             n_fail, tests_run, seed, k, s;
	int             cnt [8];

	mlsf_top dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .run_mode, .setup_block_end, .link_evt, .stn_evt,
		.param_setup_flag, .second_channel_select, .station_number, .transfer_active, .irq);
	mlsf_peer_model peer (.clk, .go, .op, .stn, .code, .xfer, .link_evt, .stn_evt);

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic close_out();
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Word comparison
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// A spent wait counts as a mismatch
	task automatic bound(input int n);
		if (n >= 50) begin
			n_fail++;
			close_out();
		end
	endtask

	// Expected flag word
	function automatic logic [31:0] flg(input logic su, p1, p2, xa, input logic [7:0] sq);
		return {16'h0000, sq, 4'h0, xa, p2, p1, su};
	endfunction

	// Bus write; address and data released as each is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic pa, pw;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		for (n = 0; n < 50 && (pa || pw); n++) begin
			@(posedge clk);
			if (pa && s_axi_awready === 1'b1) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready === 1'b1) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		bound(n);
		for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) @(posedge clk);
		bound(n);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Bus read with check of data and response
	task automatic rdchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
		input string what);
		int n;
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		// Ready is looked at from the edge after arvalid is raised
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_arready === 1'b1) begin
				break;
			end
		end
		bound(n);
		s_axi_arvalid <= 1'b0;
		for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) @(posedge clk);
		bound(n);
		rd_data = s_axi_rdata;
		resp    = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(what, d, rd_data);
		chk("rresp", {30'h0, r}, {30'h0, resp});
	endtask

	// One peer event, then time for it to land
	task automatic ev(input logic [2:0] o, input logic [2:0] t, input logic [15:0] c);
		@(posedge clk);
		go   <= 1'b1;
		op   <= o;
		stn  <= t;
		code <= c;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Main sequence
	initial begin
		{rstn, setup_block_end, go, xfer, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, op, stn, code} = '0;
		s_axi_wstrb = 4'hF;
		run_mode    = 1'b1;
		seed        = 47774;
		n_fail      = 0;
		tests_run   = 0;
		exp_seq     = 8'h00;
		cnt         = '{default: 0};
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdchk(OFF_CTRL, 32'h0000_0300, RESP_OKAY, "ctrl reset");
		// Release in run counts as run entry, so the setup window is open
		rdchk(OFF_FLAGS, flg(1, 0, 0, 0, 8'h00), RESP_OKAY, "flags reset");
		setup_block_end <= 1'b1;
		@(posedge clk);
		setup_block_end <= 1'b0;
		rdchk(8'hFC, 32'h0, RESP_SLVERR, "unmapped");
		wr(8'hFC, 32'h0000_0001);
		chk("bresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(OFF_CTRL, 32'h0000_0F21);
		chk("bresp ctrl", {30'h0, RESP_OKAY}, {30'h0, resp});
		rdchk(OFF_CTRL, 32'h0000_0A21, RESP_OKAY, "retry clamp");
		chk("chan select", 32'h1, {31'h0, second_channel_select});
		chk("station", 32'h2, {29'h0, station_number});
		wr(OFF_CTRL, 32'h0000_0121);
		ev(3'h0, 3'h0, 16'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdchk(OFF_CODE1, 32'h0000_18A4, RESP_OKAY, "code1 param");
		wr(OFF_IRQ_MASK, 32'h0000_001F);
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		ev(3'h1, 3'h0, 16'h0);
		rdchk(OFF_CODE2, 32'h0000_0EE0, RESP_OKAY, "code2 param");
		rdchk(OFF_FLAGS, flg(0, 1, 1, 0, 8'h00), RESP_OKAY, "param flags");
		for (k = 0; k < 2; k++) begin
			code = 16'($random(seed));
			ev(3'(2 + k), 3'h0, code);
			rdchk(OFF_CODE1 + 8'(4 * k), {16'h0, code}, RESP_OKAY, "comm code");
		end
		wr(OFF_FLAGS, 32'hFFFF_FFFF);
		chk("bresp ro", {30'h0, RESP_OKAY}, {30'h0, resp});
		rdchk(OFF_FLAGS, flg(0, 1, 1, 0, 8'h00), RESP_OKAY, "flags ro");
		wr(OFF_IRQ_STAT, 32'h0000_001F);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		ev(3'h5, 3'h3, 16'h0);
		rdchk(OFF_FLAGS, flg(0, 1, 1, 0, 8'h00), RESP_OKAY, "one miss");
		ev(3'h5, 3'h3, 16'h0);
		exp_seq = 8'h08;
		cnt[3]  = 1;
		rdchk(OFF_FLAGS, flg(0, 1, 1, 0, exp_seq), RESP_OKAY, "retries out");
		for (k = 0; k < 6; k++) begin
			s = (k == 0) ? 2 : {$random(seed)} % 8;
			ev(3'h4, 3'(s), 16'h0);
			if (s != 2) begin
				exp_seq[s] = 1'b1;
				cnt[s]++;
			end
		end
		xfer <= 1'b1;
		// Peer model and flag each add one edge before the read samples
		repeat (2) @(posedge clk);
		rdchk(OFF_FLAGS, flg(0, 1, 1, 1, exp_seq), RESP_OKAY, "seq flags");
		chk("xfer on", 32'h1, {31'h0, transfer_active});
		xfer <= 1'b0;
		for (k = 0; k < 8; k++) begin
			rdchk(OFF_CNT_BASE + 8'(4 * k), 32'(cnt[k]), RESP_OKAY, "count");
		end
		chk("xfer off", 32'h0, {31'h0, transfer_active});
		rdchk(OFF_IRQ_STAT, 32'h0000_0010, RESP_OKAY, "irq stat");
		run_mode <= 1'b0;
		repeat (2) @(posedge clk);
		run_mode <= 1'b1;
		repeat (3) @(posedge clk);
		chk("setup on", 32'h1, {31'h0, param_setup_flag});
		rdchk(OFF_FLAGS, flg(1, 0, 0, 0, 8'h00), RESP_OKAY, "run clear");
		rdchk(OFF_CODE1, 32'h0, RESP_OKAY, "code1 clear");
		rdchk(OFF_CNT_BASE + 8'h0C, 32'h0, RESP_OKAY, "count clear");
		setup_block_end <= 1'b1;
		@(posedge clk);
		setup_block_end <= 1'b0;
		repeat (2) @(posedge clk);
		chk("setup off", 32'h0, {31'h0, param_setup_flag});
		close_out();
	end
endmodule
